// ===== rtl/dac_load_pkg.sv
// Shared constants, carrier types and helpers for the serial DAC load logic.
// Assumes a 10 MHz system clock and a host-driven serial clock of its own.
package dac_load_pkg;

  // Frame and code geometry
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 16;
  localparam int NARROW_CODE_BITS = 14;
  localparam int COUNT_BITS = 5;
  localparam logic [COUNT_BITS-1:0] LAST_BIT_COUNT = 5'h0f;
  localparam logic [COUNT_BITS-1:0] FRAME_DONE_COUNT = 5'h10;

  // Reset and special code values
  localparam logic [CODE_BITS-1:0] CLEAR_CODE = 16'h0000;
  localparam logic [CODE_BITS-1:0] BIPOLAR_ZERO_CODE = 16'h8000;
  localparam logic [CODE_BITS-1:0] SHIFT_RESET = 16'h0000;

  // Buffer depth between link and core
  localparam int WORD_FIFO_DEPTH = 4;

  // Clock rate and track-and-hold time
  localparam longint CLK_HZ = 10_000_000;
  localparam longint HOLD_TIME_NS = 5000;
  localparam longint HOLD_CYCLES_RAW = (HOLD_TIME_NS * CLK_HZ) / 1_000_000_000;
  localparam int HOLD_CYCLES = (HOLD_CYCLES_RAW < 1) ? 1 : int'(HOLD_CYCLES_RAW);
  localparam int HOLD_COUNT_BITS = 7;

  // One received frame with its update mode
  typedef struct packed {
    logic auto_update;
    logic [CODE_BITS-1:0] code;
  } load_word_t;

  // Deferred update sequencing
  typedef enum logic [1:0] {
    UPD_IDLE,
    UPD_ARMED
  } update_state_t;

  // Keep only the significant bits of the chosen resolution
  function automatic logic [CODE_BITS-1:0] trim_code(input logic [CODE_BITS-1:0] code, input int res_bits);
    logic [CODE_BITS-1:0] keep;
    keep = (res_bits >= CODE_BITS) ? {CODE_BITS{1'b1}} : ~((CODE_BITS)'((1 << (CODE_BITS - res_bits)) - 1));
    return code & keep;
  endfunction : trim_code

  // Output code to signed level: straight binary or offset binary
  function automatic logic [CODE_BITS-1:0] code_to_level(input logic [CODE_BITS-1:0] code, input logic bipolar);
    return bipolar ? (code ^ BIPOLAR_ZERO_CODE) : code;
  endfunction : code_to_level

endpackage : dac_load_pkg

// ===== rtl/serial_dac_load_interface.sv
// Serial loading, update sequencing and DAC latch of a multiplying DAC,
// plus the small word FIFO between the serial-clock side and the core.
// Assumes the host drives serial_clk, serial_in, frame_select_n and
// load_strobe_n; clear_n and bipolar_range are board-level pins.
// The link side runs on serial_clk alone; only a toggle and a held word cross.
// A word that arrives while the FIFO is full replaces the one still waiting.

// Small FIFO built from flip-flops, valid/ready on both sides
module word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // Pointer and occupancy widths
  localparam int PTR_BITS = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_BITS = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_BITS-1:0] wr_ptr;
  logic [PTR_BITS-1:0] rd_ptr;
  logic [CNT_BITS-1:0] fill;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (fill != CNT_BITS'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = store[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointer and fill tracking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_BITS'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_BITS'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + CNT_BITS'(push) - CNT_BITS'(pop);
    end
  end
endmodule : word_fifo

module serial_dac_load_interface #(
  parameter int RESOLUTION = dac_load_pkg::CODE_BITS,
  parameter int FIFO_DEPTH = dac_load_pkg::WORD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic frame_select_n,
  input wire logic load_strobe_n,
  input wire logic clear_n,
  input wire logic bipolar_range,
  output logic [dac_load_pkg::CODE_BITS-1:0] latch_code,
  output logic [dac_load_pkg::CODE_BITS-1:0] output_code,
  output logic [dac_load_pkg::CODE_BITS-1:0] level_code,
  output logic track_hold,
  output logic word_pending
);

  // ---------------- Serial clock domain ----------------
  // Link-side counter, shifter and held word
  logic [dac_load_pkg::COUNT_BITS-1:0] bit_count;
  logic [dac_load_pkg::CODE_BITS-1:0] shift_reg;
  logic [dac_load_pkg::CODE_BITS-1:0] link_word;
  logic link_toggle;
  logic bit_gate;

  // Counter gate: open only for the first 16 falling edges of a frame
  assign bit_gate = (bit_count != dac_load_pkg::FRAME_DONE_COUNT);

  // Bit counter, cleared by frame select high since the clock may stop
  always_ff @(negedge serial_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      bit_count <= '0;
    end else if (bit_gate) begin
      bit_count <= bit_count + 1'b1;
    end
  end

  // Shift in MSB first on falling edges while the frame is open
  always_ff @(negedge serial_clk) begin
    if (!frame_select_n && bit_gate) begin
      shift_reg <= {shift_reg[dac_load_pkg::CODE_BITS-2:0], serial_in};
    end
  end

  // Capture the complete word on the 16th edge; held for the crossing
  always_ff @(negedge serial_clk) begin
    if (!frame_select_n && bit_count == dac_load_pkg::LAST_BIT_COUNT) begin
      link_word <= {shift_reg[dac_load_pkg::CODE_BITS-2:0], serial_in};
    end
  end

  // Word-complete event as a toggle; constant under reset
  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_toggle <= 1'b0;
    end else if (!frame_select_n && bit_count == dac_load_pkg::LAST_BIT_COUNT) begin
      link_toggle <= ~link_toggle;
    end
  end

  // ---------------- System clock domain ----------------
  logic [2:0] toggle_sync;
  logic [1:0] frame_sync;
  logic [1:0] strobe_sync;
  logic [1:0] clear_sync;
  logic [1:0] range_sync;
  logic frame_low_d;
  logic strobe_low_d;
  logic frame_fall;
  logic strobe_fall;
  logic word_event;
  logic frame_auto;
  logic event_waiting;
  logic [dac_load_pkg::CODE_BITS-1:0] word_capture;
  logic word_auto;
  // FIFO and update path
  dac_load_pkg::load_word_t fifo_in;
  dac_load_pkg::load_word_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  dac_load_pkg::update_state_t update_state;
  logic [dac_load_pkg::CODE_BITS-1:0] staged_code;
  logic [dac_load_pkg::HOLD_COUNT_BITS-1:0] hold_count;
  logic load_now;
  logic defer_load;
  logic [dac_load_pkg::CODE_BITS-1:0] next_latch;

  // Two-flop synchronisers for every asynchronous level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toggle_sync <= '0;
      frame_sync <= 2'b11;
      strobe_sync <= 2'b11;
      clear_sync <= 2'b11;
      range_sync <= 2'b00;
    end else begin
      toggle_sync <= {toggle_sync[1:0], link_toggle};
      frame_sync <= {frame_sync[0], frame_select_n};
      strobe_sync <= {strobe_sync[0], load_strobe_n};
      clear_sync <= {clear_sync[0], clear_n};
      range_sync <= {range_sync[0], bipolar_range};
    end
  end

  // Edge detection on synchronised levels only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_low_d <= 1'b0;
      strobe_low_d <= 1'b0;
    end else begin
      frame_low_d <= !frame_sync[1];
      strobe_low_d <= !strobe_sync[1];
    end
  end

  // Falling edges and the crossed word event
  assign frame_fall = !frame_sync[1] && !frame_low_d;
  assign strobe_fall = !strobe_sync[1] && !strobe_low_d;
  assign word_event = toggle_sync[2] ^ toggle_sync[1];

  // Update mode picked by the strobe level just after frame select falls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_auto <= 1'b1;
    end else if (frame_fall) begin
      frame_auto <= !strobe_sync[1];
    end
  end

  // Hold a crossed word and its frame's mode until the FIFO takes it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_waiting <= 1'b0;
      word_capture <= dac_load_pkg::SHIFT_RESET;
      word_auto <= 1'b1;
    end else begin
      if (word_event) begin
        event_waiting <= 1'b1;
        word_capture <= link_word;
        word_auto <= frame_auto;
      end else if (fifo_in_ready) begin
        event_waiting <= 1'b0;
      end
    end
  end

  // FIFO entry: mode taken before the next frame can change it
  always_comb begin
    fifo_in.auto_update = word_auto;
    fifo_in.code = dac_load_pkg::trim_code(word_capture, RESOLUTION);
  end

  // Status: a crossed word still waits for FIFO space
  assign word_pending = event_waiting;

  word_fifo #(
    .WIDTH($bits(dac_load_pkg::load_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) word_fifo_inst (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(fifo_in),
    .in_valid(event_waiting),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // Drain stalls while a deferred word waits for its strobe
  assign fifo_out_ready = (update_state == dac_load_pkg::UPD_IDLE);
  assign load_now = fifo_out_valid && fifo_out_ready && fifo_out.auto_update;
  assign defer_load = (update_state == dac_load_pkg::UPD_ARMED) && strobe_fall;

  // Deferred update sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      update_state <= dac_load_pkg::UPD_IDLE;
      staged_code <= dac_load_pkg::CLEAR_CODE;
    end else begin
      unique case (update_state)
        dac_load_pkg::UPD_IDLE: begin
          if (fifo_out_valid && !fifo_out.auto_update) begin
            staged_code <= fifo_out.code;
            update_state <= dac_load_pkg::UPD_ARMED;
          end
        end
        dac_load_pkg::UPD_ARMED: begin
          if (strobe_fall && clear_sync[1]) begin
            update_state <= dac_load_pkg::UPD_IDLE;
          end
        end
      endcase
    end
  end

  // Next latch value: clear wins, then deferred, then automatic
  always_comb begin
    next_latch = latch_code;
    if (!clear_sync[1]) begin
      next_latch = dac_load_pkg::CLEAR_CODE;
    end else if (defer_load) begin
      next_latch = staged_code;
    end else if (load_now) begin
      next_latch = fifo_out.code;
    end
  end

  // DAC latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_code <= dac_load_pkg::CLEAR_CODE;
    end else begin
      latch_code <= next_latch;
    end
  end

  // Track-and-hold: after a deferred latch load, freeze the output to all but clears and automatic loads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_count <= '0;
    end else if (!clear_sync[1]) begin
      hold_count <= '0;
    end else if (defer_load) begin
      hold_count <= dac_load_pkg::HOLD_COUNT_BITS'(dac_load_pkg::HOLD_CYCLES);
    end else if (hold_count != '0) begin
      hold_count <= hold_count - 1'b1;
    end
  end

  // Hold flag straight from the counter
  assign track_hold = (hold_count != '0);

  // Output code follows the latch except while holding, when only clears and automatic loads pass
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_code <= dac_load_pkg::CLEAR_CODE;
    end else if (!clear_sync[1] || load_now) begin
      output_code <= next_latch;
    end else if (hold_count == dac_load_pkg::HOLD_COUNT_BITS'(1)) begin
      output_code <= latch_code;
    end else if (hold_count == '0 && !defer_load) begin
      output_code <= latch_code;
    end
  end

  // Signed output level: straight binary or offset binary
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_code <= dac_load_pkg::CLEAR_CODE;
    end else begin
      level_code <= dac_load_pkg::code_to_level(output_code, range_sync[1]);
    end
  end

endmodule : serial_dac_load_interface

// ===== bench/host_serial_model.sv
// Host serial port model: link clock, data, frame select and load strobe.
// Link clock runs at 32 ns inside frames and for stray pulses with no frame open; the bench calls its tasks.
module host_serial_model (
  output logic serial_clk,
  output logic serial_in,
  output logic frame_select_n,
  output logic load_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle link, no frame open
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    frame_select_n = 1'b1;
    load_strobe_n = 1'b0;
  end

  // One frame of n falling edges, MSB first; defer keeps the strobe high
  task automatic send_word(input logic [15:0] w, input logic defer, input int n);
    load_strobe_n = defer;
    #107;
    frame_select_n = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      #16 serial_clk = 1'b1;
      // Data moves on the rising edge so it stands at the falling one
      serial_in = w[15 - (i % 16)] ^ (i >= 16);
      #16 serial_clk = 1'b0;
    end
    #16 frame_select_n = 1'b1;
    serial_in = ~serial_in;
  endtask : send_word

  // Link clock pulses with no frame open; the device must ignore them
  task automatic stray_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #16 serial_clk = 1'b1;
      serial_in = i[0];
      #16 serial_clk = 1'b0;
    end
    #16;
  endtask : stray_clocks

  // Deferred update pulse, strobe back high before any new frame
  task automatic pulse_strobe();
    load_strobe_n = 1'b0;
    #500;
    load_strobe_n = 1'b1;
    #300;
  endtask : pulse_strobe
endmodule : host_serial_model

// ===== bench/serial_dac_load_interface_asserts.sv
// Checker for the serial DAC load block, bound to every instance.
// Sees only top ports; all properties sample on clk.
module dac_load_checker #(
  parameter int RESOLUTION = 16,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load_strobe_n,
  input wire logic clear_n,
  input wire logic bipolar_range,
  input wire logic [15:0] latch_code,
  input wire logic [15:0] output_code,
  input wire logic [15:0] level_code,
  input wire logic track_hold,
  input wire logic word_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] hold_len;

  // Length of the running hold
  always_ff @(posedge clk) begin
    if (!rst_n || !track_hold) hold_len <= 8'h00;
    else hold_len <= hold_len + 8'h01;
  end

  clear_forces_a: assert property (!clear_n [*4] |-> latch_code == 16'h0000 && output_code == 16'h0000)
    else $error("clear did not zero the codes");
  unipolar_level_a: assert property (!bipolar_range [*4] |-> level_code == $past(output_code))
    else $error("unipolar level wrong");
  bipolar_level_a: assert property (bipolar_range [*4] |-> level_code == ($past(output_code) ^ 16'h8000))
    else $error("bipolar level wrong");
  hold_frozen_a: assert property ($rose(track_hold) |-> $stable(output_code) [*8])
    else $error("output moved during hold");
  hold_length_a: assert property ($fell(track_hold) && clear_n && $past(clear_n, 3) |-> hold_len == 8'h32)
    else $error("hold length wrong");
  hold_end_a: assert property ($fell(track_hold) |-> output_code == latch_code)
    else $error("output not loaded at hold end");
  output_tracks_a: assert property (!track_hold |-> output_code == latch_code)
    else $error("output differs from latch");
  strobe_cause_a: assert property ($rose(track_hold) |-> !$past(load_strobe_n))
    else $error("hold without strobe");

  cover property ($rose(track_hold));
  cover property (word_pending [*8]);
  cover property (bipolar_range && level_code == 16'h0000);
endmodule : dac_load_checker

bind serial_dac_load_interface dac_load_checker #(.RESOLUTION(RESOLUTION), .FIFO_DEPTH(FIFO_DEPTH)) dac_load_checker_inst (
  .clk(clk), .rst_n(rst_n), .load_strobe_n(load_strobe_n), .clear_n(clear_n), .bipolar_range(bipolar_range),
  .latch_code(latch_code), .output_code(output_code), .level_code(level_code), .track_hold(track_hold),
  .word_pending(word_pending));

// ===== bench/test_serial_dac_load_interface.sv
// Self-checking bench for the serial DAC load block.
// The host model drives the link; the bench drives clear, range and reset.
module test_serial_dac_load_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, clear_n, bipolar_range, track_hold, word_pending;
  logic serial_clk, serial_in, frame_select_n, load_strobe_n;
  logic [15:0] latch_code, output_code, level_code;
  logic [15:0] latch_narrow;
  int n_mismatch, n_tests;

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  host_serial_model host_serial_model_inst (.serial_clk(serial_clk), .serial_in(serial_in),
    .frame_select_n(frame_select_n), .load_strobe_n(load_strobe_n));
  serial_dac_load_interface serial_dac_load_interface_inst (.clk(clk), .rst_n(rst_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .frame_select_n(frame_select_n), .load_strobe_n(load_strobe_n), .clear_n(clear_n),
    .bipolar_range(bipolar_range), .latch_code(latch_code), .output_code(output_code), .level_code(level_code),
    .track_hold(track_hold), .word_pending(word_pending));
  // 14-bit variant on the same link
  serial_dac_load_interface #(.RESOLUTION(14)) serial_dac_load_interface_narrow_inst (.clk(clk), .rst_n(rst_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .frame_select_n(frame_select_n), .load_strobe_n(load_strobe_n),
    .clear_n(clear_n), .bipolar_range(bipolar_range), .latch_code(latch_narrow), .output_code(), .level_code(),
    .track_hold(), .word_pending());

  task automatic complete_run();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : cycles

  // Bounded wait for a latch value and hold state
  task automatic wait_for(input logic [15:0] exp, input logic th);
    int k;
    for (k = 0; k < 80 && !(latch_code === exp && track_hold === th); k++) cycles(1);
    if (k == 80) begin
      n_mismatch++;
      $display("unexpected at %0t: wait for latch %h expired", $time, exp);
      complete_run();
    end
  endtask : wait_for

  task automatic auto_codes();
    logic [15:0] t [5] = '{16'hffff, 16'h8000, 16'h0001, 16'h0000, 16'ha5c3};
    foreach (t[i]) begin
      host_serial_model_inst.send_word(t[i], 1'b0, 16);
      wait_for(t[i], 1'b0);
      cycles(2);
      check(level_code, t[i]);
      check(latch_narrow, t[i] & 16'hfffc);
    end
  endtask : auto_codes

  task automatic bipolar_codes();
    logic [31:0] t [3] = '{32'h8000_0000, 32'h0000_8000, 32'hffff_7fff};
    bipolar_range = 1'b1;
    foreach (t[i]) begin
      host_serial_model_inst.send_word(t[i][31:16], 1'b0, 16);
      wait_for(t[i][31:16], 1'b0);
      cycles(2);
      check(level_code, t[i][15:0]);
    end
    bipolar_range = 1'b0;
  endtask : bipolar_codes

  task automatic extra_edges();
    host_serial_model_inst.send_word(16'h1234, 1'b0, 20);
    wait_for(16'h1234, 1'b0);
    host_serial_model_inst.send_word(16'hbeef, 1'b0, 10);
    cycles(20);
    check(latch_code, 16'h1234);
    host_serial_model_inst.stray_clocks(20);
    host_serial_model_inst.send_word(16'h0f0f, 1'b0, 16);
    wait_for(16'h0f0f, 1'b0);
  endtask : extra_edges

  task automatic deferred_queue();
    logic [15:0] prev;
    prev = 16'h0f0f;
    for (int i = 0; i < 6; i++) host_serial_model_inst.send_word(16'h1000 | 16'(i), 1'b1, 16);
    cycles(4);
    check(latch_code, 16'h0f0f);
    check({15'h0000, word_pending}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      host_serial_model_inst.pulse_strobe();
      wait_for(16'h1000 | 16'(i), 1'b1);
      check(output_code, prev);
      wait_for(16'h1000 | 16'(i), 1'b0);
      prev = 16'h1000 | 16'(i);
      cycles(4);
    end
    check({15'h0000, word_pending}, 16'h0000);
  endtask : deferred_queue

  task automatic clear_test();
    clear_n = 1'b0;
    cycles(4);
    check(latch_code, 16'h0000);
    check(output_code, 16'h0000);
    clear_n = 1'b1;
    cycles(4);
  endtask : clear_test

  // Main sequence
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    // Reset starts high so that its falling edge also clears the link toggle
    rst_n = 1'b1;
    clear_n = 1'b1;
    bipolar_range = 1'b0;
    #5 rst_n = 1'b0;
    cycles(16);
    rst_n = 1'b1;
    cycles(4);
    check(latch_code, 16'h0000);
    check(output_code, 16'h0000);
    check(level_code, 16'h0000);
    check({14'h0000, track_hold, word_pending}, 16'h0000);
    auto_codes();
    bipolar_codes();
    extra_edges();
    deferred_queue();
    clear_test();
    complete_run();
  end
endmodule : test_serial_dac_load_interface
